// ---- design/indicator_alarm_status_bits.v ----
// Status and control words of the analog indicator loop
`timescale 1ns/100ps
`default_nettype none
`include "indicator_alarm_consts.vh"

module indicator_alarm_status_bits #(
  parameter [15:0] LOOP_NUM    = 16'h0001,
  parameter [7:0]  CHAN_BASE   = 8'h00,
  parameter        CNT_W       = 16,
  parameter        SCAN_CYCLES = `SCAN_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Alarm detection and loop state, same clock domain
  input  wire [7:0]  alarm_cond,
  input  wire        config_changed,
  input  wire        loop_event,
  // Pushbutton switches
  input  wire [2:0]  faceplate_press,
  input  wire [2:0]  pb_sustained,
  // Modbus coil access
  input  wire [15:0] coil_addr,
  input  wire        coil_rd,
  input  wire        coil_wr,
  input  wire        coil_wdata,
  output reg         coil_ack_q,
  output reg         coil_miss_q,
  output reg         coil_rdata_q,
  // Local link word access
  input  wire [7:0]  link_chan,
  input  wire [3:0]  link_param,
  input  wire        link_rd,
  input  wire        link_wr,
  input  wire [15:0] link_wdata,
  output reg         link_ack_q,
  output reg         link_miss_q,
  output reg  [15:0] link_rdata_q,
  // Loop state
  output reg  [2:0]  switch_input_state_q,
  output reg         scan_tick_q
);

  localparam [CNT_W-1:0] SCAN_LAST = SCAN_CYCLES - 1;

  // Stored bits
  reg  [7:0]       act_q;
  reg  [7:0]       unack_q;
  reg  [7:0]       en_q;
  reg  [1:0]       oos_q;
  reg              cc_q;
  reg              evu_q;
  reg              eva_q;
  reg  [2:0]       pend_q;
  reg  [CNT_W-1:0] scan_cnt_q;

  // Faceplate pins pass two flops, a third keeps the edge history
  reg  [2:0]       fp_meta_q;
  reg  [2:0]       fp_sync_q;
  reg  [2:0]       fp_last_q;

  wire [2:0] fp_edge = fp_sync_q & ~fp_last_q;

  // Scan divider
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scan_cnt_q  <= {CNT_W{1'b0}};
      scan_tick_q <= 1'b0;
    end else begin
      scan_tick_q <= (scan_cnt_q == SCAN_LAST);
      if (scan_cnt_q == SCAN_LAST)
        scan_cnt_q <= {CNT_W{1'b0}};
      else
        scan_cnt_q <= scan_cnt_q + 1'b1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fp_meta_q <= 3'h0;
      fp_sync_q <= 3'h0;
      fp_last_q <= 3'h0;
    end else begin
      fp_meta_q <= faceplate_press;
      fp_sync_q <= fp_meta_q;
      fp_last_q <= fp_sync_q;
    end
  end

  // Address decode
  wire [16:0] coil_base = `COIL_BASE +
                          `COIL_STRIDE * ({1'b0, LOOP_NUM} - 17'h00001);
  wire [16:0] coil_ofs  = {1'b0, coil_addr} - coil_base;
  wire        coil_hit  = ({1'b0, coil_addr} >= coil_base) &&
                          (coil_ofs < `COIL_SPAN);
  wire        coil_w2   = coil_ofs[`COIL_WORD_SEL];
  wire [3:0]  coil_bit  = coil_ofs[3:0];

  wire        link_p1   = (link_param == `PARAM_STATUS);
  wire        link_w1   = link_p1 &&
                          (link_chan == CHAN_BASE + `CHAN_W1_OFS);
  wire        link_w2   = link_p1 &&
                          (link_chan == CHAN_BASE + `CHAN_W2_OFS);

  // Host write vectors, one mask and one data word per status word
  wire [15:0] coil_onehot = 16'h0001 << coil_bit;
  wire        cw_ok       = coil_wr && coil_hit;
  wire        lw1_ok      = link_wr && link_w1;
  wire        lw2_ok      = link_wr && link_w2;
  reg  [15:0] c1_mask;
  reg  [15:0] c2_mask;
  reg  [15:0] w1_mask;
  reg  [15:0] w2_mask;
  reg  [15:0] w1_data;
  reg  [15:0] w2_data;

  // A coil write touches one bit of one word
  always @* begin
    c1_mask = 16'h0000;
    c2_mask = 16'h0000;
    if (cw_ok) begin
      if (coil_w2)
        c2_mask = coil_onehot;
      else
        c1_mask = coil_onehot;
    end
  end

  // Coil and link may hit one word together; the coil owns its own bit,
  // the link keeps every other bit of its word
  always @* begin
    w1_mask = c1_mask;
    w2_mask = c2_mask;
    if (lw1_ok)
      w1_mask = 16'hffff;
    if (lw2_ok)
      w2_mask = 16'hffff;
    w1_data = (c1_mask & {16{coil_wdata}}) | (~c1_mask & link_wdata);
    w2_data = (c2_mask & {16{coil_wdata}}) | (~c2_mask & link_wdata);
  end

  // Per-alarm views of the host write and of the alarm state
  wire [7:0]  live;
  wire [7:0]  rise;
  wire [7:0]  unack_wr;
  wire [7:0]  unack_wd;
  wire [7:0]  en_wr;
  wire [7:0]  en_wd;
  wire [31:0] hw_mask = {w2_mask, w1_mask};
  wire [31:0] hw_data = {w2_data, w1_data};

  // Word images
  wire [15:0] word1;
  wire [15:0] word2;
  wire [31:0] words;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_alarm
      localparam integer B = (i / 4) * 16 + (i % 4) * `ALARM_STRIDE;
      // Out of service and disable both hold the alarm inactive
      assign live[i]     = alarm_cond[i] & en_q[i] &
                           ~oos_q[i/4];
      assign rise[i]     = scan_tick_q & live[i] & ~act_q[i];
      assign unack_wr[i] = hw_mask[B + `FLD_UNACK];
      assign unack_wd[i] = hw_data[B + `FLD_UNACK];
      assign en_wr[i]    = hw_mask[B + `FLD_EN];
      assign en_wd[i]    = hw_data[B + `FLD_EN];

      assign words[B + `FLD_ACT]   = act_q[i];
      assign words[B + `FLD_UNACK] = unack_q[i];
      assign words[B + `FLD_EN]    = en_q[i];
    end
  endgenerate

  // All eight alarms in one process, so each vector has a single driver
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_q   <= 8'h00;
      unack_q <= {8{`UNACK_RST}};
      en_q    <= {8{`EN_RST}};
    end else begin
      // Active bit only changes on scan; host writes are dropped
      if (scan_tick_q)
        act_q <= live;
      // A new alarm beats a host clear in the same cycle
      unack_q <= rise |
                 (~rise & unack_wr & unack_wd) |
                 (~rise & ~unack_wr & unack_q);
      en_q    <= (en_wr & en_wd) | (~en_wr & en_q);
    end
  end

  assign words[`BIT_OOS]      = oos_q[0];
  assign words[15:`BIT_PB_LO] = switch_input_state_q;
  assign words[16 + `BIT_OOS] = oos_q[1];
  assign words[16 + `BIT_CC]  = cc_q;
  assign words[16 + `BIT_EVU] = evu_q;
  assign words[16 + `BIT_EVA] = eva_q;
  assign word1 = words[15:0];
  assign word2 = words[31:16];

  // Out of service bits, one per word
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oos_q <= {2{`OOS_RST}};
    end else begin
      if (w1_mask[`BIT_OOS])
        oos_q[0] <= w1_data[`BIT_OOS];
      if (w2_mask[`BIT_OOS])
        oos_q[1] <= w2_data[`BIT_OOS];
    end
  end

  // Configuration and loop event bits follow their inputs once per scan
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cc_q  <= 1'b0;
      eva_q <= 1'b0;
    end else if (scan_tick_q) begin
      cc_q  <= config_changed;
      eva_q <= loop_event;
    end
  end

  // An event starting in the clearing cycle still latches
  wire evu_set = scan_tick_q && loop_event && !eva_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evu_q <= 1'b0;
    end else begin
      if (evu_set)
        evu_q <= 1'b1;
      else if (w2_mask[`BIT_EVU])
        evu_q <= w2_data[`BIT_EVU];
    end
  end

  // Pushbuttons: a press waits for the next scan, then acts once
  wire [2:0] host_press = w1_mask[15:`BIT_PB_LO] &
                          w1_data[15:`BIT_PB_LO];
  wire [2:0] new_press  = host_press | fp_edge;
  reg  [2:0] sw_next;
  integer    k;

  // Momentary switches drop back at the scan after the one that closes them, so a
  // host that polls slower than the scan may never see them closed
  always @* begin
    sw_next = switch_input_state_q;
    for (k = 0; k < 3; k = k + 1) begin
      if (pb_sustained[k]) begin
        if (pend_q[k])
          sw_next[k] = ~switch_input_state_q[k];
      end else begin
        sw_next[k] = pend_q[k];
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q               <= 3'h0;
      switch_input_state_q <= {3{`PB_RST}};
    end else begin
      if (scan_tick_q) begin
        // Presses arriving in the scan cycle carry to the next scan
        pend_q               <= new_press;
        switch_input_state_q <= sw_next;
      end else begin
        pend_q <= pend_q | new_press;
      end
    end
  end

  // Read muxes; a miss reads as zero
  reg        coil_bit_val;
  reg [15:0] link_word;

  always @* begin
    coil_bit_val = 1'b0;
    if (coil_hit) begin
      if (coil_w2)
        coil_bit_val = word2[coil_bit];
      else
        coil_bit_val = word1[coil_bit];
    end
  end

  always @* begin
    link_word = `ZERO_WORD;
    if (link_w1)
      link_word = word1;
    else if (link_w2)
      link_word = word2;
  end

  // Coil answer, one cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coil_ack_q   <= 1'b0;
      coil_miss_q  <= 1'b0;
      coil_rdata_q <= 1'b0;
    end else begin
      coil_ack_q  <= coil_rd | coil_wr;
      coil_miss_q <= (coil_rd | coil_wr) & ~coil_hit;
      if (coil_rd)
        coil_rdata_q <= coil_bit_val;
    end
  end

  // Link answer, one cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_ack_q   <= 1'b0;
      link_miss_q  <= 1'b0;
      link_rdata_q <= `ZERO_WORD;
    end else begin
      link_ack_q  <= link_rd | link_wr;
      link_miss_q <= (link_rd | link_wr) & ~(link_w1 | link_w2);
      if (link_rd)
        link_rdata_q <= link_word;
    end
  end

endmodule // indicator_alarm_status_bits

`default_nettype wire

// ---- common/indicator_alarm_consts.vh ----
// Constants for the analog indicator loop status words
`ifndef INDICATOR_ALARM_CONSTS_VH
`define INDICATOR_ALARM_CONSTS_VH

// Coil map: each loop owns 32 coils at the start of a 48-coil block
`define COIL_BASE     17'h00128
`define COIL_STRIDE   17'h00030
`define COIL_SPAN     17'h00020
`define COIL_WORD_SEL 4

// Local link map: channel n+4 and n+5, parameter 1
`define CHAN_W1_OFS   8'h04
`define CHAN_W2_OFS   8'h05
`define PARAM_STATUS  4'h1

// Per-alarm field layout, three bits each
`define ALARM_STRIDE  3
`define FLD_ACT       0
`define FLD_UNACK     1
`define FLD_EN        2

// Upper bits of the two words
`define BIT_OOS       12
`define BIT_PB_LO     13
`define BIT_CC        13
`define BIT_EVU       14
`define BIT_EVA       15

// Reset values
`define EN_RST        1'b1
`define UNACK_RST     1'b0
`define OOS_RST       1'b0
`define PB_RST        1'b0
`define ZERO_WORD     16'h0000

// Scan cycle timing
`define SCAN_TIME_US  1000
`define CLK_MHZ       25

`endif

// ---- test/loop_status_checker.sv ----
// Bus timing and scan period checks for the indicator loop status words
`timescale 1ns/100ps
`default_nettype none
module loop_status_checker #(
  parameter [15:0] LOOP_NUM    = 16'h0001,
  parameter [7:0]  CHAN_BASE   = 8'h00,
  parameter        SCAN_CYCLES = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Coil bus
  input wire logic [15:0] coil_addr,
  input wire logic        coil_rd,
  input wire logic        coil_wr,
  input wire logic        coil_ack_q,
  input wire logic        coil_miss_q,
  // Link bus
  input wire logic [7:0]  link_chan,
  input wire logic [3:0]  link_param,
  input wire logic        link_rd,
  input wire logic        link_wr,
  input wire logic        link_ack_q,
  input wire logic        link_miss_q,
  input wire logic [15:0] link_rdata_q,
  // Scan
  input wire logic        scan_tick_q
);
  localparam [15:0] FIRST = 16'h0128 + 16'h0030 * (LOOP_NUM - 16'h0001);
  logic [15:0] gap_q;
  wire coil_req = coil_rd | coil_wr;
  wire link_req = link_rd | link_wr;
  wire coil_out = (coil_addr < FIRST) || (coil_addr > FIRST + 16'h001f);
  wire link_hit = (link_chan == CHAN_BASE + 8'h04)
                  || (link_chan == CHAN_BASE + 8'h05);
  wire link_out = !(link_hit && link_param == 4'h1);

  // Clocks since the last tick, so the period is checked without a long repeat
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= scan_tick_q ? 16'h0001 : gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_coil_ack_lat: assert property (coil_req |=> coil_ack_q)
    else $error("coil ack missing");
  chk_coil_no_spur: assert property (!coil_req |=> !coil_ack_q)
    else $error("coil ack without request");
  chk_coil_map: assert property (coil_req |=> coil_miss_q == $past(coil_out))
    else $error("coil miss wrong");
  chk_link_ack_map: assert property (link_req |=> link_ack_q
    && link_miss_q == $past(link_out)) else $error("link answer wrong");
  chk_link_miss_zero: assert property (link_rd && link_out |=>
    link_rdata_q == 16'h0000) else $error("link miss data not zero");
  chk_rdata_hold: assert property (!link_rd |=> $stable(link_rdata_q))
    else $error("link read data moved");
  chk_scan_period: assert property (scan_tick_q == (gap_q == SCAN_CYCLES))
    else $error("scan tick period wrong");
  chk_miss_with_ack: assert property ((coil_miss_q |-> coil_ack_q)
    and (link_miss_q |-> link_ack_q)) else $error("miss without ack");

  cover property (coil_miss_q);
  cover property (link_ack_q && !link_miss_q);
  cover property (scan_tick_q);
endmodule // loop_status_checker
`default_nettype wire

// ---- test/loop_host.sv ----
// Host model that reaches the loop words over coils and the local link
`timescale 1ns/100ps
`default_nettype none
module loop_host (
  // Clock
  input  wire logic        clk,
  // Coil bus
  output var  logic [15:0] coil_addr,
  output var  logic        coil_rd,
  output var  logic        coil_wr,
  output var  logic        coil_wdata,
  // Link bus
  output var  logic [7:0]  link_chan,
  output var  logic [3:0]  link_param,
  output var  logic        link_rd,
  output var  logic        link_wr,
  output var  logic [15:0] link_wdata
);
  initial begin
    {coil_addr, coil_rd, coil_wr, coil_wdata} = 19'h00000;
    {link_chan, link_param, link_rd, link_wr, link_wdata} = 30'h00000000;
  end
  // Strobe lives for the taking edge only; tasks return while the answer stands
  // Released coil address and link write data show the inverse so stale values never match
  task automatic coil(input logic [15:0] a, input logic w, input logic d);
    @(posedge clk) #1;
    {coil_addr, coil_rd, coil_wr, coil_wdata} = {a, !w, w, d};
    @(posedge clk) #1;
    {coil_rd, coil_wr, coil_addr} = {2'b00, ~a};
  endtask
  task automatic link(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(posedge clk) #1;
    {link_chan, link_param, link_rd, link_wr, link_wdata} = {c, 4'h1, !w, w, d};
    @(posedge clk) #1;
    {link_rd, link_wr, link_wdata} = {2'b00, ~d};
  endtask
endmodule // loop_host
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the indicator loop status words
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int SCAN = 32;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  alarm_cond = 8'h00;
  logic        config_changed = 1'b0;
  logic        loop_event = 1'b0;
  logic [2:0]  faceplate_press = 3'h0;
  logic [2:0]  pb_sustained = 3'h0;
  wire  [15:0] coil_addr, link_wdata, link_rdata_q;
  wire  [7:0]  link_chan;
  wire  [3:0]  link_param;
  wire  [2:0]  switch_input_state_q;
  wire         coil_rd, coil_wr, coil_wdata, coil_ack_q, coil_miss_q;
  wire         coil_rdata_q, link_rd, link_wr, link_ack_q, link_miss_q;
  wire         scan_tick_q;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  indicator_alarm_status_bits #(.SCAN_CYCLES(SCAN)) i_dut (
    .clk(clk), .nrst(nrst), .alarm_cond(alarm_cond),
    .config_changed(config_changed), .loop_event(loop_event),
    .faceplate_press(faceplate_press), .pb_sustained(pb_sustained),
    .coil_addr(coil_addr), .coil_rd(coil_rd), .coil_wr(coil_wr),
    .coil_wdata(coil_wdata), .coil_ack_q(coil_ack_q),
    .coil_miss_q(coil_miss_q), .coil_rdata_q(coil_rdata_q),
    .link_chan(link_chan), .link_param(link_param), .link_rd(link_rd),
    .link_wr(link_wr), .link_wdata(link_wdata), .link_ack_q(link_ack_q),
    .link_miss_q(link_miss_q), .link_rdata_q(link_rdata_q),
    .switch_input_state_q(switch_input_state_q), .scan_tick_q(scan_tick_q));
  loop_host i_host (
    .clk(clk), .coil_addr(coil_addr), .coil_rd(coil_rd), .coil_wr(coil_wr),
    .coil_wdata(coil_wdata), .link_chan(link_chan), .link_param(link_param),
    .link_rd(link_rd), .link_wr(link_wr), .link_wdata(link_wdata));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_tick;
    for (int i = 0; i < SCAN + 2 && scan_tick_q !== 1'b1; i++) @(posedge clk) #1;
    check("scan tick", {15'h0000, scan_tick_q}, 16'h0001);
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    i_host.link(c, 1'b0, 16'h0000);
    check("link ack", {15'h0000, link_ack_q}, 16'h0001);
    check("link word", link_rdata_q, exp);
  endtask

  task automatic t_reset;
    rd(8'h04, 16'h0924);
    rd(8'h05, 16'h0924);
    rd(8'h06, 16'h0000);
    check("link miss", {15'h0000, link_miss_q}, 16'h0001);
    i_host.coil(16'h0148, 1'b0, 1'b0);
    check("coil miss", {14'h0000, coil_miss_q, coil_rdata_q}, 16'h0002);
    i_host.coil(16'h013a, 1'b0, 1'b0);
    check("coil bit", {14'h0000, coil_miss_q, coil_rdata_q}, 16'h0001);
  endtask
  task automatic t_alarm;
    alarm_cond = 8'h81;
    wait_tick;
    rd(8'h04, 16'h0927);
    rd(8'h05, 16'h0f24);
    i_host.coil(16'h0129, 1'b1, 1'b0);
    i_host.coil(16'h0128, 1'b1, 1'b0);
    rd(8'h04, 16'h0925);
  endtask
  task automatic t_oos;
    i_host.coil(16'h0144, 1'b1, 1'b1);
    wait_tick;
    rd(8'h05, 16'h1d24);
    alarm_cond = 8'h00;
    i_host.coil(16'h0144, 1'b1, 1'b0);
    i_host.coil(16'h0142, 1'b1, 1'b0);
    wait_tick;
    rd(8'h05, 16'h0924);
  endtask
  task automatic t_event;
    config_changed = 1'b1;
    loop_event = 1'b1;
    wait_tick;
    rd(8'h05, 16'he924);
    i_host.coil(16'h0145, 1'b1, 1'b0);
    i_host.coil(16'h0147, 1'b1, 1'b0);
    i_host.coil(16'h0146, 1'b1, 1'b0);
    rd(8'h05, 16'ha924);
    i_host.link(8'h04, 1'b1, 16'h0003);
    rd(8'h04, 16'h0002);
  endtask
  task automatic t_pb;
    pb_sustained = 3'b001;
    i_host.coil(16'h0135, 1'b1, 1'b1);
    i_host.coil(16'h0136, 1'b1, 1'b1);
    wait_tick;
    check("switches", {13'h0000, switch_input_state_q}, 16'h0003);
    faceplate_press = 3'b100;
    wait_tick;
    faceplate_press = 3'b000;
    rd(8'h04, 16'ha002);
    wait_tick;
    rd(8'h04, 16'h2002);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    t_reset;
    t_alarm;
    t_oos;
    t_event;
    t_pb;
    end_of_test;
  end
  // Run needs some 240 clocks; eight times that means a hang
  initial begin
    #(40 * 2000);
    n_mismatch++;
    end_of_test;
  end
endmodule // tb

bind indicator_alarm_status_bits loop_status_checker #(.LOOP_NUM(LOOP_NUM),
  .CHAN_BASE(CHAN_BASE), .SCAN_CYCLES(SCAN_CYCLES)) i_chk (
  .clk(clk), .nrst(nrst), .coil_addr(coil_addr), .coil_rd(coil_rd),
  .coil_wr(coil_wr), .coil_ack_q(coil_ack_q), .coil_miss_q(coil_miss_q),
  .link_chan(link_chan), .link_param(link_param), .link_rd(link_rd),
  .link_wr(link_wr), .link_ack_q(link_ack_q), .link_miss_q(link_miss_q),
  .link_rdata_q(link_rdata_q), .scan_tick_q(scan_tick_q));
`default_nettype wire
